/* common/fcc_pkg.sv */
package fcc_pkg;
	// Register byte addresses
	localparam logic [31:0] FCC_MODE_ADDR = 32'hffff0804;
	localparam logic [31:0] FCC_CMD_ADDR = 32'hffff0808;
	localparam logic [31:0] FCC_DATA_ADDR = 32'hffff080c;
	localparam logic [31:0] FCC_TADDR_ADDR = 32'hffff0810;
	localparam logic [31:0] FCC_SIG_ADDR = 32'hffff0818;
	localparam logic [31:0] FCC_PROT_ADDR = 32'hffff081c;
	localparam logic [31:0] FCC_STA_ADDR = 32'hffff0e00;

	// Mode register fields
	localparam int FCC_MODE_IRQ_EN_BIT = 4;
	localparam int FCC_MODE_EW_EN_BIT = 3;
	localparam logic [15:0] FCC_MODE_RESET = 16'h0000;

	// Status register fields
	localparam int FCC_STA_PASS_BIT = 0;
	localparam int FCC_STA_FAIL_BIT = 1;
	localparam int FCC_STA_BUSY_BIT = 2;
	localparam int FCC_STA_IRQ_BIT = 3;
	localparam logic [15:0] FCC_STA_FIXED = 16'h0020;

	// Command codes
	localparam logic [7:0] FCC_CMD_IDLE = 8'h00;
	localparam logic [7:0] FCC_CMD_READ = 8'h01;
	localparam logic [7:0] FCC_CMD_WRITE = 8'h02;
	localparam logic [7:0] FCC_CMD_ERASE_WRITE = 8'h03;
	localparam logic [7:0] FCC_CMD_VERIFY = 8'h04;
	localparam logic [7:0] FCC_CMD_PAGE_ERASE = 8'h05;
	localparam logic [7:0] FCC_CMD_MASS_ERASE = 8'h06;
	localparam logic [7:0] FCC_CMD_READBACK = 8'h07;
	localparam logic [7:0] FCC_CMD_SIGN = 8'h0b;
	localparam logic [7:0] FCC_CMD_PROTECT = 8'h0c;
	localparam logic [7:0] FCC_CMD_PING = 8'h0f;

	// Address range, unlock key and reset values
	localparam logic [15:0] FCC_ADDR_LIMIT = 16'h77ff;
	localparam logic [15:0] FCC_KEY_DATA = 16'h3cff;
	localparam logic [15:0] FCC_KEY_ADDR = 16'h77c3;
	localparam logic [15:0] FCC_ADDR_RESET = 16'h0000;
	localparam logic [15:0] FCC_DATA_RESET = 16'h0000;
	localparam logic [15:0] FCC_ERASED = 16'hffff;
	localparam logic [23:0] FCC_SIG_RESET = 24'hffffff;
	localparam logic [23:0] FCC_LFSR_TAPS = 24'he10000;
	localparam logic [31:0] FCC_PROT_RESET = 32'h00000000;

	// Timing
	localparam int FCC_CLK_PERIOD_NS = 8;
	localparam int FCC_WRITE_TIME_US = 50;
	localparam int FCC_ERASE_WRITE_TIME_MS = 24;
	localparam int FCC_ERASE_TIME_MS = 20;
	localparam int FCC_SIGN_CYCLES = 16389;
	localparam int FCC_WRITE_CYC =
		(FCC_WRITE_TIME_US * 1000 + FCC_CLK_PERIOD_NS - 1) / FCC_CLK_PERIOD_NS;
	localparam int FCC_ERASE_WRITE_CYC =
		(FCC_ERASE_WRITE_TIME_MS * 1000000) / FCC_CLK_PERIOD_NS;
	localparam int FCC_ERASE_CYC =
		(FCC_ERASE_TIME_MS * 1000000) / FCC_CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		FCC_ST_IDLE = 3'b001,
		FCC_ST_WAIT = 3'b010,
		FCC_ST_SIGN = 3'b100
	} fcc_state_t;
endpackage

/* design/fcc_flash_array.sv */
`timescale 1ns/1ps
module fcc_flash_array
	import fcc_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int PAGE_W = 8,
	parameter int USER_WORDS = 15360
) (
	input wire logic sys_clk,
	input wire logic clkEn,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrIdx,
	input wire logic [15:0] wrData,
	input wire logic pageErase,
	input wire logic massErase,
	input wire logic [ADDR_W-1:0] rdIdx,
	output logic [15:0] rdData
);
	localparam int DEPTH = 2 ** ADDR_W;
	logic [15:0] mem [DEPTH];

	assign rdData = mem[rdIdx];

	// Erase first, so a combined erase and program leaves the new word
	always_ff @(posedge sys_clk) begin
		if (clkEn) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (massErase && i < USER_WORDS)
					mem[i] <= FCC_ERASED;
				if (pageErase && (i >> PAGE_W) == (int'(wrIdx) >> PAGE_W))
					mem[i] <= FCC_ERASED;
			end
			if (wrEn)
				mem[wrIdx] <= wrData;
		end
	end
endmodule

/* design/fcc_flash_command_controller.sv */
`timescale 1ns/1ps
module fcc_flash_command_controller
	import fcc_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int PAGE_W = 8,
	parameter int TMR_W = 22,
	parameter int WRITE_CYC = FCC_WRITE_CYC,
	parameter int ERASE_WRITE_CYC = FCC_ERASE_WRITE_CYC,
	parameter int ERASE_CYC = FCC_ERASE_CYC,
	parameter int MASS_ERASE_CYC = FCC_ERASE_CYC,
	parameter int SIGN_CYC = FCC_SIGN_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [31:0] busAddr,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [31:0] busWdata,
	output logic [31:0] busRdata,
	output logic busRdValid,
	output logic dataAbort,
	output logic flashIrq
);
	localparam int USER_WORDS = (int'(FCC_ADDR_LIMIT) + 1) / 2;
	function automatic logic [ADDR_W-1:0] wordIdx(input logic [15:0] a);
		return a[ADDR_W:1];
	endfunction
	function automatic logic isEwCode(input logic [7:0] c);
		return c == FCC_CMD_WRITE || c == FCC_CMD_ERASE_WRITE ||
			c == FCC_CMD_PAGE_ERASE || c == FCC_CMD_MASS_ERASE;
	endfunction
	fcc_state_t state_r;
	logic [7:0] cmd_r;
	logic [15:0] mode_r;
	logic [15:0] data_r;
	logic [15:0] addr_r;
	logic [23:0] sig_r;
	logic [23:0] lfsr_r;
	logic [31:0] prot_r;
	logic protDone_r;
	logic pass_r;
	logic fail_r;
	logic irqSt_r;
	logic [TMR_W-1:0] tmr_r;
	logic [ADDR_W-1:0] sigIdx_r;
	logic [31:0] busRdata_r;
	logic busRdValid_r;
	logic dataAbort_r;
	logic flashIrq_r;
	logic [15:0] arrRd;
	wire idle = state_r == FCC_ST_IDLE;
	wire selMode = busAddr == FCC_MODE_ADDR;
	wire selCmd = busAddr == FCC_CMD_ADDR;
	wire selData = busAddr == FCC_DATA_ADDR;
	wire selTaddr = busAddr == FCC_TADDR_ADDR;
	wire selSig = busAddr == FCC_SIG_ADDR;
	wire selProt = busAddr == FCC_PROT_ADDR;
	wire selSta = busAddr == FCC_STA_ADDR;
	wire rdSta = busRd && selSta;
	wire [7:0] code = busWdata[7:0];
	wire wrCmd = busWr && selCmd && idle;
	wire modeIrq = mode_r[FCC_MODE_IRQ_EN_BIT];
	wire modeEw = mode_r[FCC_MODE_EW_EN_BIT];
	wire addrBad = busWdata[15:0] > FCC_ADDR_LIMIT;
	wire wrTaddr = busWr && selTaddr && idle;
	wire keyOk = data_r == FCC_KEY_DATA && addr_r == FCC_KEY_ADDR;
	wire isEw = isEwCode(code);
	wire isRsv = !(code <= FCC_CMD_MASS_ERASE || code == FCC_CMD_SIGN ||
		code == FCC_CMD_PROTECT || code == FCC_CMD_PING);
	// erase/program gated by mode bit 3
	wire ewBlock = isEw && !modeEw;
	// unlock key required for mass erase
	wire keyBad = code == FCC_CMD_MASS_ERASE && !keyOk;
	wire protBad = code == FCC_CMD_PROTECT && protDone_r;
	wire verBad = code == FCC_CMD_VERIFY && arrRd != data_r;
	wire cmdFail = ewBlock || keyBad || protBad || verBad;
	wire goOk = wrCmd && !cmdFail;
	wire arrWr = goOk &&
		(code == FCC_CMD_WRITE || code == FCC_CMD_ERASE_WRITE);
	wire pageErase = goOk &&
		(code == FCC_CMD_ERASE_WRITE || code == FCC_CMD_PAGE_ERASE);
	wire massErase = goOk && code == FCC_CMD_MASS_ERASE;
	wire goTimed = goOk && isEw;
	wire goSign = goOk && code == FCC_CMD_SIGN;
	// ping and untimed commands end at once
	wire finNow = wrCmd && !isRsv && code != FCC_CMD_IDLE &&
		!goTimed && !goSign;
	wire finRun = !idle && tmr_r == '0;
	wire finEv = finNow || finRun;
	wire finPass = finRun || !cmdFail;
	wire [7:0] finCode = finRun ? cmd_r : code;
	wire [TMR_W-1:0] runCyc =
		code == FCC_CMD_WRITE ? TMR_W'(WRITE_CYC - 1) :
		code == FCC_CMD_ERASE_WRITE ? TMR_W'(ERASE_WRITE_CYC - 1) :
		code == FCC_CMD_PAGE_ERASE ? TMR_W'(ERASE_CYC - 1) :
		TMR_W'(MASS_ERASE_CYC - 1);
	wire [ADDR_W-1:0] rdIdx =
		state_r == FCC_ST_SIGN ? sigIdx_r : wordIdx(addr_r);
	wire lfsrIn = ^(lfsr_r & FCC_LFSR_TAPS) ^ ^arrRd;
	wire [15:0] staVal = FCC_STA_FIXED |
		(16'(irqSt_r) << FCC_STA_IRQ_BIT) |
		(16'(!idle) << FCC_STA_BUSY_BIT) |
		(16'(fail_r) << FCC_STA_FAIL_BIT) |
		(16'(pass_r) << FCC_STA_PASS_BIT);
	wire [31:0] rdMux =
		selMode ? {16'h0000, mode_r} :
		selCmd ? {24'h000000, cmd_r} :
		selData ? {16'h0000, data_r} :
		selTaddr ? {16'h0000, addr_r} :
		selSig ? {8'h00, sig_r} :
		selProt ? prot_r :
		selSta ? {16'h0000, staVal} : 32'h00000000;

	fcc_flash_array #(
		.ADDR_W(ADDR_W),
		.PAGE_W(PAGE_W),
		.USER_WORDS(USER_WORDS)
	) i_fcc_flash_array (
		.sys_clk(sys_clk),
		.clkEn(clkEn),
		.wrEn(arrWr),
		.wrIdx(wordIdx(addr_r)),
		.wrData(data_r),
		.pageErase(pageErase),
		.massErase(massErase),
		.rdIdx(rdIdx),
		.rdData(arrRd)
	);

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= FCC_ST_IDLE;
			tmr_r <= '0;
			sigIdx_r <= '0;
			lfsr_r <= FCC_SIG_RESET;
			sig_r <= FCC_SIG_RESET;
		end else if (clkEn) begin
			case (state_r)
			FCC_ST_IDLE: begin
				if (goTimed) begin
					state_r <= FCC_ST_WAIT;
					tmr_r <= runCyc;
				end else if (goSign) begin
					state_r <= FCC_ST_SIGN;
					tmr_r <= TMR_W'(SIGN_CYC - 1);
					sigIdx_r <= '0;
					lfsr_r <= FCC_SIG_RESET;
				end
			end
			FCC_ST_WAIT: begin
				if (finRun)
					state_r <= FCC_ST_IDLE;
				else
					tmr_r <= tmr_r - 1'b1;
			end
			FCC_ST_SIGN: begin
				lfsr_r <= {lfsr_r[22:0], lfsrIn};
				sigIdx_r <= sigIdx_r + 1'b1;
				if (finRun) begin
					state_r <= FCC_ST_IDLE;
					sig_r <= {lfsr_r[22:0], lfsrIn};
				end else begin
					tmr_r <= tmr_r - 1'b1;
				end
			end
			default: state_r <= FCC_ST_IDLE;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_r <= FCC_CMD_IDLE;
			mode_r <= FCC_MODE_RESET;
			data_r <= FCC_DATA_RESET;
			addr_r <= FCC_ADDR_RESET;
			prot_r <= FCC_PROT_RESET;
			protDone_r <= 1'b0;
		end else if (clkEn) begin
			if (busWr && selMode)
				mode_r <= busWdata[15:0];
			if (wrCmd)
				cmd_r <= code;
			if ((finEv && finCode <= FCC_CMD_MASS_ERASE) ||
				(wrCmd && code == FCC_CMD_IDLE))
				cmd_r <= FCC_CMD_READBACK;
			if (goOk && code == FCC_CMD_READ)
				data_r <= arrRd;
			else if (busWr && selData && idle)
				data_r <= busWdata[15:0];
			if (wrTaddr && !addrBad)
				addr_r <= busWdata[15:0];
			if (busWr && selProt && idle && !protDone_r)
				prot_r <= busWdata;
			// lock stored value, mass erase unlocks
			if (goOk && code == FCC_CMD_PROTECT)
				protDone_r <= 1'b1;
			else if (massErase)
				protDone_r <= 1'b0;
		end
	end

	// Status flags: a completion beats a same-cycle clearing read
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pass_r <= 1'b0;
			fail_r <= 1'b0;
			irqSt_r <= 1'b0;
			flashIrq_r <= 1'b0;
			dataAbort_r <= 1'b0;
			busRdata_r <= '0;
			busRdValid_r <= 1'b0;
		end else if (clkEn) begin
			// pass / fail, cleared by status read
			pass_r <= (finEv && finPass) || (pass_r && !rdSta);
			fail_r <= (finEv && !finPass) || (fail_r && !rdSta);
			irqSt_r <= (finEv && modeIrq) || (irqSt_r && !rdSta);
			flashIrq_r <= finEv && modeIrq;
			dataAbort_r <= wrTaddr && addrBad;
			busRdValid_r <= busRd;
			if (busRd)
				busRdata_r <= rdMux;
		end
	end

	assign busRdata = busRdata_r;
	assign busRdValid = busRdValid_r;
	assign dataAbort = dataAbort_r;
	assign flashIrq = flashIrq_r;

	AST_IRQ_GATED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && finEv && !modeIrq) |=> !flashIrq)
		else $error("interrupt raised while disabled");
	AST_IRQ_RAISED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && finEv && modeIrq) |=> flashIrq && irqSt_r)
		else $error("interrupt missing on completion");
	AST_EW_BLOCKED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && wrCmd && isEw && !modeEw) |->
		(!arrWr && !pageErase && !massErase) ##1 (fail_r && idle))
		else $error("erase or program while protected");
	AST_READBACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && finEv && finCode <= FCC_CMD_MASS_ERASE) |=>
		cmd_r == FCC_CMD_READBACK)
		else $error("command register not 0x07 after command");
	AST_BUSY_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && wrCmd && code == FCC_CMD_WRITE && modeEw) |=>
		staVal[FCC_STA_BUSY_BIT] [*4])
		else $error("busy not held during program");
	AST_STA_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && rdSta && !finEv) |=> !pass_r && !fail_r && !irqSt_r)
		else $error("status bits not cleared by read");
	AST_VERIFY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && wrCmd && code == FCC_CMD_VERIFY && arrRd != data_r) |=>
		fail_r && !pass_r)
		else $error("verify mismatch not reported");
	AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && wrCmd && isRsv) |=> idle && $stable(data_r) &&
		$stable(addr_r) && $stable(mode_r))
		else $error("reserved code changed state");
	AST_PING: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clkEn && wrCmd && code == FCC_CMD_PING) |=> pass_r && idle)
		else $error("ping did not complete");
endmodule

/* tb/fcc_flash_command_controller_tb_top.sv */
`timescale 1ns/1ps
module fcc_flash_command_controller_tb_top
	import fcc_pkg::*;
;
	localparam int T_WR = 8;
	localparam int T_EW = 20;
	localparam int T_ER = 12;
	localparam int T_SG = 16;
	localparam logic [31:0] ST_IDLE = {16'h0000, FCC_STA_FIXED};
	localparam logic [31:0] ST_PASS = ST_IDLE | 32'h00000001;
	localparam logic [31:0] ST_FAIL = ST_IDLE | 32'h00000002;
	localparam logic [31:0] ST_BUSY = ST_IDLE | 32'h00000004;
	localparam logic [31:0] ST_IRQ = ST_PASS | 32'h00000008;
	localparam logic [31:0] ST_FIRQ = ST_FAIL | 32'h00000008;
	logic sys_clk;
	logic rst_n;
	logic clkEn;
	logic [31:0] busAddr;
	logic busWr;
	logic busRd;
	logic [31:0] busWdata;
	logic [31:0] busRdata;
	logic busRdValid;
	logic dataAbort;
	logic flashIrq;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int irqCnt = 0;
	int abortCnt = 0;
	logic [7:0] guardCodes[4] = '{FCC_CMD_WRITE, FCC_CMD_ERASE_WRITE,
		FCC_CMD_PAGE_ERASE, FCC_CMD_MASS_ERASE};
	logic [7:0] rsvdCodes[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};

	fcc_flash_command_controller #(
		.WRITE_CYC(T_WR),
		.ERASE_WRITE_CYC(T_EW),
		.ERASE_CYC(T_ER),
		.MASS_ERASE_CYC(T_ER),
		.SIGN_CYC(T_SG)
	) i_fcc_flash_command_controller (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.busAddr(busAddr),
		.busWr(busWr),
		.busRd(busRd),
		.busWdata(busWdata),
		.busRdata(busRdata),
		.busRdValid(busRdValid),
		.dataAbort(dataAbort),
		.flashIrq(flashIrq)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Pulse counters; a level held too long shows as extra pulses
	always @(negedge sys_clk) begin
		cycles = cycles + 1;
		if (flashIrq === 1'b1) irqCnt = irqCnt + 1;
		if (dataAbort === 1'b1) abortCnt = abortCnt + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			$display("Error timeout expected %0d seen %0d", 2999, cycles);
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Signature model: erased words add no parity to the feedback
	function automatic logic [31:0] sigExp(input int n);
		logic [23:0] s;
		s = FCC_SIG_RESET;
		for (int i = 0; i < n; i++)
			s = {s[22:0], ^(s & FCC_LFSR_TAPS) ^ ^FCC_ERASED};
		return {8'h00, s};
	endfunction

	task automatic endTest(input string name);
		$display("test %s done, errors so far %0d", name, num_errors);
	endtask

	// Strobes drop one cycle after rising; a spare cycle separates transfers
	task automatic busWrite(input logic [31:0] a, input logic [31:0] d);
		busAddr = a;
		busWdata = d;
		busWr = 1'b1;
		@(negedge sys_clk);
		busWr = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic rdChk(input logic [31:0] a, input logic [31:0] exp,
		input string what);
		busAddr = a;
		busRd = 1'b1;
		@(negedge sys_clk);
		busRd = 1'b0;
		chk("read valid", 32'h1, {31'h0, busRdValid});
		chk(what, exp, busRdata);
		@(negedge sys_clk);
	endtask

	task automatic cmdTail(input logic [7:0] code, input logic [31:0] exp,
		input int i0);
		chk("irq pulses", {31'h0, exp[3]}, irqCnt - i0);
		rdChk(FCC_CMD_ADDR, code <= 8'h06 ? 32'h7 : {24'h0, code}, "command");
	endtask

	task automatic runCmd(input logic [7:0] code, input logic [31:0] exp);
		int i0;
		i0 = irqCnt;
		busWrite(FCC_CMD_ADDR, {24'h0, code});
		rdChk(FCC_STA_ADDR, exp, "status");
		cmdTail(code, exp, i0);
	endtask

	// Busy must cover exactly n cycles: last busy read, then done read
	task automatic timedCmd(input logic [7:0] code, input int n,
		input logic [31:0] exp);
		int i0;
		i0 = irqCnt;
		busWrite(FCC_CMD_ADDR, {24'h0, code});
		rdChk(FCC_STA_ADDR, ST_BUSY, "status busy start");
		repeat (n - 4) @(negedge sys_clk);
		busAddr = FCC_STA_ADDR;
		busRd = 1'b1;
		@(negedge sys_clk);
		chk("status busy end", ST_BUSY, busRdata);
		@(negedge sys_clk);
		busRd = 1'b0;
		chk("status done", exp, busRdata);
		@(negedge sys_clk);
		cmdTail(code, exp, i0);
	endtask

	task automatic setTarget(input logic [31:0] a, input logic [31:0] d);
		busWrite(FCC_TADDR_ADDR, a);
		busWrite(FCC_DATA_ADDR, d);
	endtask

	task automatic flashRd(input logic [31:0] a, input logic [31:0] exp);
		busWrite(FCC_TADDR_ADDR, a);
		runCmd(FCC_CMD_READ, ST_IRQ);
		rdChk(FCC_DATA_ADDR, exp, "flash word");
	endtask

	initial begin
		int a0;
		rst_n = 1'b0;
		clkEn = 1'b1;
		busWr = 1'b0;
		busRd = 1'b0;
		busAddr = 32'h00000000;
		busWdata = 32'h00000000;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		rdChk(FCC_CMD_ADDR, 32'h0, "command reset");
		rdChk(FCC_MODE_ADDR, 32'h0, "mode reset");
		rdChk(FCC_STA_ADDR, ST_IDLE, "status reset");
		rdChk(FCC_TADDR_ADDR, 32'h0, "address reset");
		rdChk(FCC_SIG_ADDR, 32'h00ffffff, "signature reset");
		rdChk(FCC_PROT_ADDR, 32'h0, "protection reset");
		rdChk(32'hffff0900, 32'h0, "unmapped");
		endTest("reset");
		busWrite(FCC_MODE_ADDR, 32'h10);
		runCmd(FCC_CMD_PING, ST_IRQ);
		rdChk(FCC_STA_ADDR, ST_IDLE, "status cleared");
		busWrite(FCC_MODE_ADDR, 32'h0);
		runCmd(FCC_CMD_PING, ST_PASS);
		runCmd(FCC_CMD_IDLE, ST_IDLE);
		setTarget(32'h10, 32'h1234);
		foreach (guardCodes[i]) runCmd(guardCodes[i], ST_FAIL);
		endTest("commands");
		busWrite(FCC_MODE_ADDR, 32'h18);
		timedCmd(FCC_CMD_WRITE, T_WR, ST_IRQ);
		flashRd(32'h10, 32'h1234);
		runCmd(FCC_CMD_VERIFY, ST_IRQ);
		busWrite(FCC_DATA_ADDR, 32'h1235);
		runCmd(FCC_CMD_VERIFY, ST_FIRQ);
		setTarget(32'h200, 32'ha5a5);
		timedCmd(FCC_CMD_WRITE, T_WR, ST_IRQ);
		setTarget(32'h12, 32'h5555);
		timedCmd(FCC_CMD_ERASE_WRITE, T_EW, ST_IRQ);
		flashRd(32'h10, 32'hffff);
		flashRd(32'h12, 32'h5555);
		busWrite(FCC_TADDR_ADDR, 32'h12);
		timedCmd(FCC_CMD_PAGE_ERASE, T_ER, ST_IRQ);
		flashRd(32'h12, 32'hffff);
		flashRd(32'h200, 32'ha5a5);
		endTest("program and erase");
		foreach (rsvdCodes[i]) runCmd(rsvdCodes[i], ST_IDLE);
		rdChk(FCC_DATA_ADDR, 32'ha5a5, "data kept");
		// Enable low: the write must not land
		clkEn = 1'b0;
		busWrite(FCC_DATA_ADDR, 32'h1111);
		clkEn = 1'b1;
		rdChk(FCC_DATA_ADDR, 32'ha5a5, "data frozen");
		a0 = abortCnt;
		busWrite(FCC_TADDR_ADDR, 32'h7800);
		chk("aborts", 32'h1, abortCnt - a0);
		rdChk(FCC_TADDR_ADDR, 32'h200, "address kept");
		busWrite(FCC_TADDR_ADDR, 32'h77ff);
		chk("aborts", 32'h1, abortCnt - a0);
		rdChk(FCC_TADDR_ADDR, 32'h77ff, "address top");
		endTest("reserved and abort");
		busWrite(FCC_PROT_ADDR, 32'h5);
		runCmd(FCC_CMD_PROTECT, ST_IRQ);
		runCmd(FCC_CMD_PROTECT, ST_FIRQ);
		busWrite(FCC_PROT_ADDR, 32'h6);
		rdChk(FCC_PROT_ADDR, 32'h5, "protection");
		timedCmd(FCC_CMD_SIGN, T_SG, ST_IRQ);
		rdChk(FCC_SIG_ADDR, sigExp(T_SG), "signature");
		setTarget(32'h77c2, 32'h3cff);
		runCmd(FCC_CMD_MASS_ERASE, ST_FIRQ);
		setTarget(32'h77c3, 32'h3cff);
		timedCmd(FCC_CMD_MASS_ERASE, T_ER, ST_IRQ);
		flashRd(32'h200, 32'hffff);
		runCmd(FCC_CMD_PROTECT, ST_IRQ);
		endTest("protect, signature, mass erase");
		wrap_up();
	end
endmodule
